// *** hdl/cfdrx_pkg.sv ***
package cfdrx_pkg;

   // ==========================================================
   // Register offsets (byte addresses on the APB).
   localparam logic [7:0] CFDRX_OFS_CTRL = 8'h00;
   localparam logic [7:0] CFDRX_OFS_RXF0C = 8'h04;
   localparam logic [7:0] CFDRX_OFS_RXF1C = 8'h08;
   localparam logic [7:0] CFDRX_OFS_TOP0 = 8'h0c;
   localparam logic [7:0] CFDRX_OFS_TOP1 = 8'h10;
   localparam logic [7:0] CFDRX_OFS_RX_FIFO1_STATUS_REG = 8'h14;

   // ==========================================================
   // Field positions.
   localparam int CFDRX_CTRL_INIT_BIT = 0;
   localparam int CFDRX_CTRL_CCE_BIT = 1;
   localparam int CFDRX_CTRL_DBGEN_BIT = 2;
   localparam int CFDRX_CFG_START_LSB = 0;
   localparam int CFDRX_CFG_SIZE_LSB = 16;
   localparam int CFDRX_STS_IDX_LSB = 0;
   localparam int CFDRX_STS_DMS_LSB = 24;

   // ==========================================================
   // Reset values and sizes.
   localparam logic [2:0] CFDRX_CTRL_RST = 3'h1;
   localparam logic [22:0] CFDRX_CFG_RST = 23'h000000;
   localparam logic [6:0] CFDRX_MAX_ELEMS = 7'h40;
   localparam logic [15:0] CFDRX_ELEM_BYTES = 16'h0048;

   // ==========================================================
   // Debug message handling states; idle encodes as zero.
   typedef enum logic [1:0] {
      CFDRX_DMS_IDLE,
      CFDRX_DMS_GOT1,
      CFDRX_DMS_GOT2,
      CFDRX_DMS_READY
   } cfdrx_dms_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } cfdrx_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } cfdrx_apb_rsp_t;

endpackage

// *** hdl/cfdrx_top.sv ***
// How it works
// RQ1: Hardware computes next FIFO element read address.
// RQ2: Top pointer wraps to start, even size one.
// RQ3: Init request forces debug machine to Idle.
// RQ4: Bus-off returns debug machine to Idle.
// RQ5: Debug state always readable in FIFO1 status.
// RQ6: Debug disabled keeps machine Idle, reception untouched.
// RQ7: Debug messages advance machine; reset gives Idle.
// RQ8: Idle encodes zero and reset loads it.
`timescale 1ns/1ps
module cfdrx_top
   import cfdrx_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire cfdrx_apb_req_t apb_req,
   output cfdrx_apb_rsp_t apb_rsp,
   input wire logic debug_msg_rx,
   input wire logic bus_off,
   input wire logic dma_done,
   output logic dbg_dma_req,
   output logic init_request
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [2:0] ctrl;
      logic [1:0][22:0] cfg;
      logic [1:0][5:0] idx;
      cfdrx_dms_t dms;
      cfdrx_apb_rsp_t rsp;
      logic dma_req;
   } cfdrx_state_t;

   cfdrx_state_t st_r;
   cfdrx_state_t st_nxt;

   logic setup;
   logic access;
   logic [1:0][15:0] top_addr;
   logic [1:0][5:0] idx_inc;

   assign setup = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable & st_r.rsp.pready;

   // Address of the next element for each FIFO, and its wrapped index.
   // Sizes above the index range clamp, so the pointer never runs past
   // the last element that the counter can name.
   always_comb begin
      logic [6:0] sz;
      sz = 7'h00;
      for (int f = 0; f < 2; f++) begin
         top_addr[f] = 16'(st_r.cfg[f][15:0] + 16'(st_r.idx[f]) *
            CFDRX_ELEM_BYTES); // RQ1
         sz = st_r.cfg[f][22:16];
         if (sz > CFDRX_MAX_ELEMS) begin
            sz = CFDRX_MAX_ELEMS;
         end
         if (sz == 7'h00 || ({1'b0, st_r.idx[f]} + 7'h01) >= sz) begin
            idx_inc[f] = 6'h00; // RQ2
         end else begin
            idx_inc[f] = 6'(st_r.idx[f] + 6'h01);
         end
      end
   end

   // Next state: bus answers, register writes, read side effects, and
   // the debug message machine.
   always_comb begin
      st_nxt = st_r;
      st_nxt.rsp.pready = setup;
      if (setup) begin
         st_nxt.rsp.prdata = 32'h00000000;
         st_nxt.rsp.pslverr = 1'b0;
         if (apb_req.paddr == CFDRX_OFS_CTRL) begin
            st_nxt.rsp.prdata = {29'h0, st_r.ctrl};
         end else if (apb_req.paddr == CFDRX_OFS_RXF0C) begin
            st_nxt.rsp.prdata = {9'h0, st_r.cfg[0]};
         end else if (apb_req.paddr == CFDRX_OFS_RXF1C) begin
            st_nxt.rsp.prdata = {9'h0, st_r.cfg[1]};
         end else if (apb_req.paddr == CFDRX_OFS_TOP0) begin
            st_nxt.rsp.prdata = {16'h0, top_addr[0]}; // RQ1
         end else if (apb_req.paddr == CFDRX_OFS_TOP1) begin
            st_nxt.rsp.prdata = {16'h0, top_addr[1]}; // RQ1
         end else if (apb_req.paddr == CFDRX_OFS_RX_FIFO1_STATUS_REG) begin
            st_nxt.rsp.prdata = {6'h0, st_r.dms, 18'h0, st_r.idx[1]}; // RQ5
         end else begin
            st_nxt.rsp.pslverr = 1'b1;
         end
      end
      // Writes and top-pointer reads take effect at the completing edge.
      if (access && apb_req.pwrite) begin
         if (apb_req.paddr == CFDRX_OFS_CTRL) begin
            st_nxt.ctrl = apb_req.pwdata[2:0];
         end else if (apb_req.paddr == CFDRX_OFS_RXF0C) begin
            st_nxt.cfg[0] = apb_req.pwdata[22:0];
            st_nxt.idx[0] = 6'h00;
         end else if (apb_req.paddr == CFDRX_OFS_RXF1C) begin
            st_nxt.cfg[1] = apb_req.pwdata[22:0];
            st_nxt.idx[1] = 6'h00;
         end
      end else if (access) begin
         if (apb_req.paddr == CFDRX_OFS_TOP0) begin
            st_nxt.idx[0] = idx_inc[0]; // RQ2
         end else if (apb_req.paddr == CFDRX_OFS_TOP1) begin
            st_nxt.idx[1] = idx_inc[1]; // RQ2
         end
      end
      // The config change bit deliberately has no effect on the machine.
      if (st_r.ctrl[CFDRX_CTRL_INIT_BIT] | bus_off |
          ~st_r.ctrl[CFDRX_CTRL_DBGEN_BIT]) begin
         st_nxt.dms = CFDRX_DMS_IDLE; // RQ3 RQ4 RQ6
      end else begin
         case (st_r.dms)
            CFDRX_DMS_IDLE: begin
               if (debug_msg_rx) begin
                  st_nxt.dms = CFDRX_DMS_GOT1; // RQ7
               end
            end
            CFDRX_DMS_GOT1: begin
               if (debug_msg_rx) begin
                  st_nxt.dms = CFDRX_DMS_GOT2; // RQ7
               end
            end
            CFDRX_DMS_GOT2: begin
               if (debug_msg_rx) begin
                  st_nxt.dms = CFDRX_DMS_READY; // RQ7
               end
            end
            default: begin
               if (dma_done) begin
                  st_nxt.dms = CFDRX_DMS_IDLE; // RQ7
               end
            end
         endcase
      end
      st_nxt.dma_req = (st_nxt.dms == CFDRX_DMS_READY);
   end

   // Single register stage; reset loads Idle and safe configuration.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r.ctrl <= CFDRX_CTRL_RST;
         st_r.cfg <= {CFDRX_CFG_RST, CFDRX_CFG_RST};
         st_r.idx <= 12'h000;
         st_r.dms <= CFDRX_DMS_IDLE; // RQ8
         st_r.rsp <= '0;
         st_r.dma_req <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign apb_rsp = st_r.rsp;
   assign dbg_dma_req = st_r.dma_req;
   assign init_request = st_r.ctrl[CFDRX_CTRL_INIT_BIT];

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence top0_read;
      access && !apb_req.pwrite && apb_req.paddr == CFDRX_OFS_TOP0;
   endsequence

   sequence top1_read;
      access && !apb_req.pwrite && apb_req.paddr == CFDRX_OFS_TOP1;
   endsequence

   sequence dbg_live;
      !st_r.ctrl[CFDRX_CTRL_INIT_BIT] && !bus_off &&
         st_r.ctrl[CFDRX_CTRL_DBGEN_BIT];
   endsequence

   chk_top_addr_val: assert property ( // RQ1
      top0_read |-> apb_rsp.prdata[15:0] == 16'(st_r.cfg[0][15:0] +
         16'(st_r.idx[0]) * CFDRX_ELEM_BYTES))
      else $error("Top pointer address wrong.");
   chk_top_wrap_last: assert property ( // RQ2
      top0_read and ({1'b0, st_r.idx[0]} + 7'h01 == st_r.cfg[0][22:16])
      |=> st_r.idx[0] == 6'h00)
      else $error("Top pointer did not wrap.");
   chk_single_elem: assert property ( // RQ2
      (st_r.cfg[0][22:16] == 7'h01) and top0_read |=> $stable(top_addr[0]))
      else $error("Single element FIFO pointer moved.");
   chk_init_idle: assert property ( // RQ3
      st_r.ctrl[CFDRX_CTRL_INIT_BIT] |=> dbg_dma_req == 1'b0 &&
         st_r.dms == CFDRX_DMS_IDLE)
      else $error("Init request left machine busy.");
   chk_busoff_idle: assert property ( // RQ4
      bus_off |=> st_r.dms == CFDRX_DMS_IDLE)
      else $error("Bus-off left machine busy.");
   chk_dms_report: assert property ( // RQ5
      access && !apb_req.pwrite && apb_req.paddr == CFDRX_OFS_RX_FIFO1_STATUS_REG |->
         apb_rsp.prdata[25:24] == $past(st_r.dms))
      else $error("Status field does not show state.");
   chk_dbg_off_idle: assert property ( // RQ6
      !st_r.ctrl[CFDRX_CTRL_DBGEN_BIT] [*2] |-> st_r.dms == CFDRX_DMS_IDLE)
      else $error("Disabled machine not idle.");
   chk_dbg_advance: assert property ( // RQ7
      dbg_live and st_r.dms == CFDRX_DMS_GOT2 && debug_msg_rx |=>
         st_r.dms == CFDRX_DMS_READY ##0 dbg_dma_req)
      else $error("Debug message did not advance.");
   chk_reset_idle: assert property ( // RQ8
      @(posedge clk) disable iff (1'b0) !reset_n |=> st_r.dms == 2'b00)
      else $error("Reset did not load idle.");

   // ==========================================================
   // Checks on the second FIFO and on the waiting debug states.
   // The second pointer is guarded on its own, because an index slip
   // between the two FIFOs would still pass the first FIFO's checks.
   chk_top1_addr_val: assert property ( // RQ1
      top1_read |-> apb_rsp.prdata[15:0] == 16'(st_r.cfg[1][15:0] +
         16'(st_r.idx[1]) * CFDRX_ELEM_BYTES))
      else $error("Second top pointer address wrong.");
   chk_top1_wrap: assert property ( // RQ2
      top1_read and ({1'b0, st_r.idx[1]} + 7'h01 == st_r.cfg[1][22:16])
      |=> st_r.idx[1] == 6'h00)
      else $error("Second top pointer did not wrap.");
   // A stopped intermediate state may only move on a debug message.
   chk_got1_hold: assert property ( // RQ7
      dbg_live and st_r.dms == CFDRX_DMS_GOT1 && !debug_msg_rx |=>
         st_r.dms == CFDRX_DMS_GOT1)
      else $error("Stopped state moved without message.");
   chk_ready_hold: assert property ( // RQ7
      dbg_live and st_r.dms == CFDRX_DMS_READY && !dma_done |=>
         st_r.dms == CFDRX_DMS_READY)
      else $error("Ready state left without DMA.");
   chk_off_no_req: assert property ( // RQ6
      !st_r.ctrl[CFDRX_CTRL_DBGEN_BIT] |=> !dbg_dma_req)
      else $error("Disabled machine requested DMA.");

endmodule // cfdrx_top

// *** verification/cfdrx_dma_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// DMA that empties the debug buffer once its request is seen.
module cfdrx_dma_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic dbg_dma_req,
   input wire logic slow,
   output logic dma_done
);
   logic [3:0] cnt_r;

   // The wait is reset whenever the request drops, so a late request
   // never inherits a count from an earlier buffer.
   always_ff @(posedge clk) begin
      if (!reset_n || !dbg_dma_req) begin
         cnt_r <= 4'h0;
         dma_done <= 1'b0;
      end else if (cnt_r == (slow ? 4'h8 : 4'h1)) begin
         cnt_r <= 4'h0;
         dma_done <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 4'h1;
         dma_done <= 1'b0;
      end
   end
endmodule // cfdrx_dma_model

// *** verification/cfdrx_top_test.sv ***
`timescale 1ns/1ps
module cfdrx_top_test;
   import cfdrx_pkg::*;
   logic clk, reset_n, msg, bus_off, done, dma_req, init, slow;
   cfdrx_apb_req_t req;
   cfdrx_apb_rsp_t rsp;
   logic [32:0] notes[$];
   int err_total, check_count;

   cfdrx_top i_dut (.clk(clk), .reset_n(reset_n), .apb_req(req),
      .apb_rsp(rsp), .debug_msg_rx(msg), .bus_off(bus_off),
      .dma_done(done), .dbg_dma_req(dma_req), .init_request(init));
   cfdrx_dma_model i_dma (.clk(clk), .reset_n(reset_n),
      .dbg_dma_req(dma_req), .slow(slow), .dma_done(done));

   // ==========================================================
   // Helpers.
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("mismatches %0d, comparisons %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One APB transfer; the request is held until pready is sampled.
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      // Let one edge pass, so that a following call never drives req
      // twice in the same time step.
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] exp);
      notes.push_back(exp);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         msg <= 1'b1;
         @(posedge clk);
      end
      msg <= 1'b0;
      @(posedge clk);
   endtask

   // ==========================================================
   // Clock, watchdog and the read-data monitor.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      stop_test();
   end
   always @(posedge clk)
      if (rsp.pready === 1'b1 && req.pwrite === 1'b0)
         check({rsp.pslverr, rsp.prdata}, notes.pop_front());

   // ==========================================================
   // Main sequence.
   initial begin
      logic [15:0] seed;
      logic [15:0] st;
      logic [6:0] sz;
      seed = 16'h49ed;
      req <= '0;
      {msg, bus_off, slow} <= 3'h0;
      reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(CFDRX_OFS_CTRL, 33'h1);
      rd(CFDRX_OFS_RX_FIFO1_STATUS_REG, 33'h0);
      pulse(1);
      rd(CFDRX_OFS_RX_FIFO1_STATUS_REG, 33'h0);
      xfer(1'b1, CFDRX_OFS_CTRL, 32'h4);
      pulse(2);
      rd(CFDRX_OFS_RX_FIFO1_STATUS_REG, 33'h2000000);
      xfer(1'b1, CFDRX_OFS_CTRL, 32'h5);
      check({32'h0, init}, 33'h1);
      rd(CFDRX_OFS_RX_FIFO1_STATUS_REG, 33'h0);
      xfer(1'b1, CFDRX_OFS_CTRL, 32'h4);
      pulse(1);
      bus_off <= 1'b1;
      // Bus-off needs one edge to clear the state before the status read.
      @(posedge clk);
      rd(CFDRX_OFS_RX_FIFO1_STATUS_REG, 33'h0);
      bus_off <= 1'b0;
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         pulse(3);
         check({32'h0, dma_req}, 33'h1);
         repeat (14) @(posedge clk);
         rd(CFDRX_OFS_RX_FIFO1_STATUS_REG, 33'h0);
      end
      for (int f = 0; f < 2; f++) begin
         sz = (f == 1) ? 7'h3 : 7'h1;
         st = {4'h0, seed[11:0]};
         seed = lfsr(seed);
         xfer(1'b1, (f == 1) ? CFDRX_OFS_RXF1C : CFDRX_OFS_RXF0C,
            {9'h0, sz, st});
         for (int k = 0; k < 4; k++)
            rd((f == 1) ? CFDRX_OFS_TOP1 : CFDRX_OFS_TOP0, {17'h0, st +
               16'(k % int'(sz)) * CFDRX_ELEM_BYTES});
      end
      rd(CFDRX_OFS_RX_FIFO1_STATUS_REG, 33'h1);
      rd(8'h3c, 33'h100000000);
      @(posedge clk);
      stop_test();
   end
endmodule // cfdrx_top_test
